// ===== hw/dac_serial_pkg.sv
/*
 Package for the serial write port of an eight-channel voltage DAC:
 frame sizes, command word layout, sampler and channel structs.
 Assumes nothing of its surroundings.
*/
package dac_serial_pkg;
   localparam int WORD_BITS = 16;
   localparam int ABORT_EDGE = 15;
   localparam int CHAN_COUNT = 8;
   localparam int CODE_BITS = 12;
   localparam int FIFO_DEPTH = 32;
   // command word layout
   localparam int CMD_MSB = 15;
   localparam int CMD_LSB = 12;
   localparam int CODE_MSB = 11;
   localparam int CODE_LSB = 0;
   localparam int CHAN_MSB = 14;
   localparam int CHAN_LSB = 12;
   localparam logic CMD_IS_CTRL = 1'h1;
   localparam logic [2:0] CTRL_POWER_DOWN = 3'h7;
   localparam logic [2:0] CTRL_MODE = 3'h0;
   localparam logic [CODE_BITS-1:0] CODE_RESET = 12'h000;
   localparam logic [4:0] EDGE_CNT_RESET = 5'h00;

   typedef struct packed {
      logic clk;
      logic sel_n;
      logic din;
   } serial_pins_t;

   typedef struct packed {
      logic [WORD_BITS-1:0] word;
   } cmd_word_t;

   typedef struct packed {
      logic [CHAN_COUNT-1:0][CODE_BITS-1:0] code;
      logic [CHAN_COUNT-1:0] powered_down;
      logic auto_update;
   } chan_state_t;
endpackage

// ===== hw/word_fifo.sv
/*
 Synchronous FIFO with parameter width and depth, valid/ready on both sides.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module word_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic [WIDTH-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   output logic [WIDTH-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] count;
   } fifo_state_t;
   fifo_state_t s, next_s;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push, pop;

   // full only when count reaches depth; an empty FIFO must take words
   assign in_ready_o = (s.count < (AW+1)'(DEPTH));
   assign out_valid_o = (s.count != '0);
   assign out_data_o = mem[s.rd];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   always_comb begin
      next_s = s;
      if (push) next_s.wr = (s.wr == AW'(DEPTH - 1)) ? '0 : s.wr + 1'b1;
      if (pop) next_s.rd = (s.rd == AW'(DEPTH - 1)) ? '0 : s.rd + 1'b1;
      next_s.count = s.count + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) s <= '0;
      else s <= next_s;
      if (push) mem[s.wr] <= in_data_i;
   end
endmodule // word_fifo

// ===== hw/dac_serial_input_port.sv
/*
 Serial write port of an eight-channel DAC: samples the host's serial
 clock, frame select and data with mclk_i, shifts 16-bit words, commits
 whole frames through a word FIFO into the channel state, and drives the
 daisy-chain output. Assumes the serial clock is far slower than mclk_i
 (at least four mclk_i periods per half period).
*/
// Operation
// - shift data on falling clock while selected
// - commit word on select rise after sixteen
// - early select rise discards the partial word
// - chain output valid only after sixteen clocks
// - committed word decoded as control (power-down, mode or load all) or channel
// - channel code and power-down outputs held zero until first valid write
`timescale 1ns/1ps
module dac_serial_input_port
   import dac_serial_pkg::*;
#(
   parameter int WORD_LEN = WORD_BITS,
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic sclk_i,
   input wire logic sync_n_i,
   input wire logic din_i,
   output logic dout_o,
   output logic [CHAN_COUNT*CODE_BITS-1:0] chan_code_o,
   output logic [CHAN_COUNT-1:0] chan_power_down_o,
   output logic word_commit_o,
   output logic frame_abort_o,
   output logic fifo_stall_o
);
   import dac_serial_pkg::*;

   typedef struct packed {
      serial_pins_t meta;
      serial_pins_t sync;
      serial_pins_t last;
      logic [WORD_BITS-1:0] shift;
      logic [4:0] edges;
      logic in_frame;
      logic dout;
      logic commit;
      logic abort;
      logic stall;
      chan_state_t chan;
      logic [CHAN_COUNT-1:0][CODE_BITS-1:0] pending;
   } port_state_t;

   port_state_t s, next_s;
   logic [WORD_BITS-1:0] push_word;
   logic push_valid, push_ready;
   logic [WORD_BITS-1:0] pop_word;
   logic pop_valid;
   logic fall_edge, sel_fall, sel_rise;
   serial_pins_t pins_now;

   assign pins_now = '{clk: sclk_i, sel_n: sync_n_i, din: din_i};
   assign fall_edge = s.last.clk && !s.sync.clk;
   assign sel_fall = s.last.sel_n && !s.sync.sel_n;
   assign sel_rise = !s.last.sel_n && s.sync.sel_n;

   word_fifo #(
      .WIDTH(WORD_BITS),
      .DEPTH(DEPTH)
   ) u_fifo (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .in_data_i(push_word),
      .in_valid_i(push_valid),
      .in_ready_o(push_ready),
      .out_data_o(pop_word),
      .out_valid_o(pop_valid),
      .out_ready_i(1'b1)
   );

   always_comb begin
      next_s = s;
      push_word = s.shift;
      push_valid = 1'b0;
      next_s.meta = pins_now;
      next_s.sync = s.meta;
      next_s.last = s.sync;
      next_s.commit = 1'b0;
      next_s.abort = 1'b0;
      next_s.stall = !push_ready;
      if (sel_fall) begin
         next_s.in_frame = 1'b1;
         next_s.edges = EDGE_CNT_RESET;
      end
      if (s.in_frame && !s.sync.sel_n && fall_edge) begin
         next_s.shift = {s.shift[WORD_BITS-2:0], s.sync.din};
         next_s.dout = (s.edges >= 5'(WORD_LEN)) ? s.shift[WORD_BITS-1] : 1'b0;
         if (s.edges != 5'h1F) next_s.edges = s.edges + 5'h01;
      end
      // chain quiet until past sixteen
      // idle between frames too, so no stale bit reaches the next device
      if (!s.in_frame || s.edges < 5'(WORD_LEN)) next_s.dout = 1'b0;
      if (s.in_frame && sel_rise) begin
         next_s.in_frame = 1'b0;
         if (s.edges >= 5'(WORD_LEN)) begin
            push_valid = 1'b1;
            next_s.commit = push_ready;
         end else if (s.edges < 5'(ABORT_EDGE)) begin
            next_s.abort = 1'b1;
         end else begin
            // fifteen edges: undefined, dropped as abort too
            next_s.abort = 1'b1;
         end
      end
      if (pop_valid) begin
         if (pop_word[CMD_MSB] == CMD_IS_CTRL) begin
            if (pop_word[CHAN_MSB:CHAN_LSB] == CTRL_POWER_DOWN)
               next_s.chan.powered_down = pop_word[CHAN_COUNT-1:0];
            else if (pop_word[CHAN_MSB:CHAN_LSB] == CTRL_MODE)
               next_s.chan.auto_update = pop_word[0];
            else begin
               // load all channels from pending, one shot update
               next_s.chan.code = s.pending;
            end
         end else begin
            next_s.pending[pop_word[CHAN_MSB:CHAN_LSB]] = pop_word[CODE_MSB:CODE_LSB];
            if (s.chan.auto_update)
               next_s.chan.code[pop_word[CHAN_MSB:CHAN_LSB]] = pop_word[CODE_MSB:CODE_LSB];
            next_s.chan.powered_down[pop_word[CHAN_MSB:CHAN_LSB]] = 1'b0;
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         s <= '0;
         s.chan.auto_update <= 1'b1;
         s.meta <= '{clk: 1'b0, sel_n: 1'b1, din: 1'b0};
         s.sync <= '{clk: 1'b0, sel_n: 1'b1, din: 1'b0};
         s.last <= '{clk: 1'b0, sel_n: 1'b1, din: 1'b0};
      end else begin
         s <= next_s;
      end
   end

   assign dout_o = s.dout;
   assign chan_code_o = s.chan.code;
   assign chan_power_down_o = s.chan.powered_down;
   assign word_commit_o = s.commit;
   assign frame_abort_o = s.abort;
   assign fifo_stall_o = s.stall;
endmodule // dac_serial_input_port

// ===== test/dac_serial_input_port_properties.sv
/* Port checks for the serial DAC port.
   Assumes binding to its top module. */
`timescale 1ns/1ps
module dac_serial_input_port_properties
   import dac_serial_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic sync_n_i,
   input wire logic dout_o,
   input wire logic [CHAN_COUNT*CODE_BITS-1:0] chan_code_o,
   input wire logic word_commit_o,
   input wire logic frame_abort_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   // verdicts come only after select has risen
   sequence closed_s;
      $past(sync_n_i, 3) && sync_n_i;
   endsequence
   commit_timing_a: assert property (word_commit_o |-> closed_s) else $error("early commit");
   commit_pulse_a: assert property (word_commit_o |=> !word_commit_o) else $error("long commit");
   abort_timing_a: assert property (frame_abort_o |-> closed_s) else $error("early abort");
   one_verdict_a: assert property (!(word_commit_o && frame_abort_o)) else $error("both");
   code_cause_a: assert property ($changed(chan_code_o) |->
      $past(word_commit_o) || $past(word_commit_o, 2)) else $error("code moved");
   chain_idle_a: assert property (sync_n_i [*5] |-> !dout_o) else $error("chain busy");
   reset_zero_a: assert property ($fell(rst_i) |-> chan_code_o == '0) else $error("code");
endmodule // dac_serial_input_port_properties

// ===== test/host_model.sv
/* Host serial writer, paced by mclk_i.
   Assumes calls start just after a mclk_i edge. */
`timescale 1ns/1ps
module host_model (
   input wire logic mclk_i,
   input wire logic dout_i,
   output logic sclk_o = 1'b1,
   output logic sync_n_o = 1'b1,
   output logic din_o = 1'b0
);
   logic [31:0] rx = 32'h0;
   // sends n top bits of w, msb first, 400 ns clock
   task automatic send(input logic [31:0] w, input int n);
      logic [31:0] sh;
      sh = w;
      din_o <= sh[31];
      sync_n_o <= 1'b0;
      repeat (4) @(posedge mclk_i);
      for (int i = 0; i < n; i++) begin
         sclk_o <= 1'b0;
         repeat (4) @(posedge mclk_i);
         sh = sh << 1;
         sclk_o <= 1'b1;
         din_o <= sh[31];
         repeat (4) @(posedge mclk_i);
         rx <= {rx[30:0], dout_i};
      end
      sync_n_o <= 1'b1;
      din_o <= ~sh[31];
      repeat (8) @(posedge mclk_i);
   endtask
endmodule // host_model

// ===== test/dac_serial_input_port_tb.sv
/* Bench for the serial DAC port.
   Assumes package, FIFO and design compiled first. */
`timescale 1ns/1ps
module dac_serial_input_port_tb;
   import dac_serial_pkg::*;
   logic mclk_i = 1'b0;
   logic rst_i = 1'b1;
   logic sclk, sync_n, din, dout, commit, abort_p, stall;
   logic [95:0] code;
   logic [7:0] pd;
   int n_fail = 0;
   int n_compared = 0;
   int n_commit = 0;
   int n_abort = 0;
   always #25 mclk_i = ~mclk_i;
   always @(posedge mclk_i) begin
      n_commit <= n_commit + int'(commit === 1'b1);
      n_abort <= n_abort + int'(abort_p === 1'b1);
   end
   host_model i_host_model(.mclk_i(mclk_i), .dout_i(dout), .sclk_o(sclk),
      .sync_n_o(sync_n), .din_o(din));
   dac_serial_input_port i_dac_serial_input_port(.mclk_i(mclk_i), .rst_i(rst_i),
      .sclk_i(sclk), .sync_n_i(sync_n), .din_i(din), .dout_o(dout), .chan_code_o(code),
      .chan_power_down_o(pd), .word_commit_o(commit), .frame_abort_o(abort_p),
      .fifo_stall_o(stall));
   task automatic chk(input logic [95:0] got, input logic [95:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic end_of_test();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic t_chan();
      chk({pd, code}, '0);
      i_host_model.send(32'h8001_0000, 16);
      for (int c = 0; c < 8; c++) begin
         i_host_model.send({1'b0, c[2:0], 12'h5A0 + 12'(c), 16'h0000}, 16);
         chk(code[12*c +: 12], 12'h5A0 + 12'(c));
      end
      chk(n_commit, 9);
      $display("channel test done");
   endtask
   task automatic t_abort();
      logic [95:0] old;
      old = code;
      i_host_model.send(32'hFFFF_0000, 4);
      i_host_model.send(32'h0FFF_0000, 15);
      chk(n_abort, 2);
      chk(code, old);
      i_host_model.send(32'hF0A5_0000, 16);
      chk(pd, 8'hA5);
      chk(i_host_model.rx[15:0], 16'h0000);
      $display("abort test done");
   endtask
   task automatic t_chain();
      i_host_model.send(32'h1234_2ABC, 32);
      chk(i_host_model.rx, 32'h0000_1234);
      chk(code[24 +: 12], 12'hABC);
      chk(code[12 +: 12], 12'h5A1);
      chk(dout, 1'h0);
      chk(stall, 1'h0);
      $display("chain test done");
   endtask
   initial begin
      repeat (3) @(posedge mclk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge mclk_i);
      t_chan();
      t_abort();
      t_chain();
      end_of_test();
   end
   initial begin
      repeat (30000) @(posedge mclk_i);
      n_fail++;
      end_of_test();
   end
endmodule // dac_serial_input_port_tb
bind dac_serial_input_port dac_serial_input_port_properties i_props(.*);
